// ---- inc/tscp_defines.vh ----
// Constants for the tuner serial control port master
// Behaviour
// - Master raises latch_select before any shift clock pulse of a telegram.
// - Telegram is shifted most significant bit first, bit 0 last.
// - Master changes data only on falling shift clock edges and as latch_select rises.
// - With shared latch_select, master programs every device each telegram.
// - Master always sends zero in bits 7 and 6.
`ifndef TSCP_DEFINES_VH
`define TSCP_DEFINES_VH
`define TSCP_ADDR_CTRL 12'h000
`define TSCP_ADDR_WORD 12'h004
`define TSCP_ADDR_STAT 12'h008
`define TSCP_ADDR_DIV 12'h00C
`define TSCP_CTRL_GO 0
`define TSCP_STB_BIT 5
`define TSCP_CAP_MSB 4
`define TSCP_WORD_BITS 8
`define TSCP_DIV_RESET 8'h02
`define TSCP_GAP_CYC 8'h02
`endif

// ---- hdl/tscp_master.v ----
// APB-controlled master that drives the three-wire tuner control port
`timescale 1ns/1ps
`include "tscp_defines.vh"
module tscp_master (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg latch_select,
	output reg shift_clock_in,
	output reg shift_data_in
);
	localparam ST_IDLE = 3'h0;
	localparam ST_SETUP = 3'h1;
	localparam ST_LOW = 3'h2;
	localparam ST_HIGH = 3'h3;
	localparam ST_HOLD = 3'h4;
	localparam ST_GAP = 3'h5;

	// Engine state
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] shift_reg;
	reg [7:0] shift_next;
	reg [7:0] cnt_reg;
	reg [7:0] cnt_next;
	reg [2:0] bit_reg;
	reg [2:0] bit_next;
	reg [7:0] sent_reg;
	reg [7:0] sent_next;
	reg sel_next;
	reg clk_next;
	reg data_next;
	reg take_start;
	reg set_done;

	// Software visible state
	reg [7:0] word_reg;
	reg [7:0] div_reg;
	reg pend_reg;
	reg pend_next;
	reg [7:0] last_reg;
	reg [7:0] last_next;
	reg done_reg;
	reg done_next;

	// Bus answer
	reg [31:0] rd_next;
	reg pready_next;
	reg pslverr_next;

	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable;
	wire apb_wr = apb_acc & pwrite;
	wire hit_ctrl = (paddr == `TSCP_ADDR_CTRL);
	wire hit_word = (paddr == `TSCP_ADDR_WORD);
	wire hit_stat = (paddr == `TSCP_ADDR_STAT);
	wire hit_div = (paddr == `TSCP_ADDR_DIV);
	wire hit_any = hit_ctrl | hit_word | hit_stat | hit_div;
	wire busy = (state_reg != ST_IDLE) | pend_reg;
	wire go_wr = apb_wr & hit_ctrl & pwdata[`TSCP_CTRL_GO];
	wire cnt_done = (cnt_reg == 8'h00);
	wire [7:0] div_eff = (div_reg == 8'h00) ? 8'h01 : div_reg;
	// Saturates so a huge divider cannot wrap into a short gap
	wire [7:0] gap_load = (div_eff > (8'hFF - `TSCP_GAP_CYC)) ? 8'hFF : div_eff + `TSCP_GAP_CYC;

	// APB answer: registered in setup, so it stands for the access cycle only
	always @* begin
		pready_next = apb_setup;
		pslverr_next = apb_setup & ~hit_any;
	end

	// Read mux; unmapped and write cycles return zero
	always @* begin
		rd_next = 32'h00000000;
		if (apb_setup & ~pwrite) begin
			case (paddr)
				`TSCP_ADDR_WORD: begin
					rd_next = {24'h000000, word_reg};
				end
				`TSCP_ADDR_STAT: begin
					rd_next = {22'h000000, done_reg, busy, last_reg};
				end
				`TSCP_ADDR_DIV: begin
					rd_next = {24'h000000, div_reg};
				end
				default: begin
					rd_next = 32'h00000000;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= rd_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// Word register; reserved bits can never reach the wire
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_reg <= 8'h00;
		end else begin
			if (apb_wr & hit_word) begin
				word_reg <= {2'b00, pwdata[`TSCP_STB_BIT:0]};
			end
		end
	end

	// Divider register; zero is read back but treated as one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= `TSCP_DIV_RESET;
		end else begin
			if (apb_wr & hit_div) begin
				div_reg <= pwdata[7:0];
			end
		end
	end

	// Start request: one start queues while a telegram runs
	always @* begin
		pend_next = pend_reg;
		if (take_start) begin
			pend_next = 1'b0;
		end
		if (go_wr) begin
			pend_next = 1'b1;
		end
	end

	// Done flag: set by the engine wins over a clear in the same cycle
	always @* begin
		done_next = done_reg;
		if (apb_wr & hit_stat) begin
			done_next = 1'b0;
		end
		if (set_done) begin
			done_next = 1'b1;
		end
	end

	// Serial engine, next state
	always @* begin
		state_next = state_reg;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		sent_next = sent_reg;
		last_next = last_reg;
		sel_next = latch_select;
		clk_next = shift_clock_in;
		data_next = shift_data_in;
		take_start = 1'b0;
		set_done = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				clk_next = 1'b0;
				if (pend_reg & ~go_wr) begin
					take_start = 1'b1;
					// Select rises a full half period before the first clock
					sel_next = 1'b1;
					// Whole word every time, even if unchanged
					sent_next = word_reg;
					shift_next = {word_reg[6:0], 1'b0};
					data_next = word_reg[7];
					bit_next = 3'h7;
					cnt_next = div_eff;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_done) begin
					clk_next = 1'b1;
					cnt_next = div_eff;
					state_next = ST_HIGH;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			ST_HIGH: begin
				if (cnt_done) begin
					clk_next = 1'b0;
					cnt_next = div_eff;
					if (bit_reg == 3'h0) begin
						state_next = ST_HOLD;
					end else begin
						// While select is high, data moves only with the falling clock edge
						data_next = shift_reg[7];
						shift_next = {shift_reg[6:0], 1'b0};
						bit_next = bit_reg - 3'h1;
						state_next = ST_LOW;
					end
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			ST_LOW: begin
				if (cnt_done) begin
					clk_next = 1'b1;
					cnt_next = div_eff;
					state_next = ST_HIGH;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			ST_HOLD: begin
				if (cnt_done) begin
					// Exactly eight clocks sent, so the device applies this word
					sel_next = 1'b0;
					// The sent copy, since software may rewrite the word meanwhile
					last_next = sent_reg;
					cnt_next = gap_load;
					state_next = ST_GAP;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			ST_GAP: begin
				// Keeps select low long enough before a next telegram
				if (cnt_done) begin
					set_done = 1'b1;
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: begin
				sel_next = 1'b0;
				clk_next = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	// Serial engine and status registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			latch_select <= 1'b0;
			shift_clock_in <= 1'b0;
			shift_data_in <= 1'b0;
			shift_reg <= 8'h00;
			cnt_reg <= 8'h00;
			bit_reg <= 3'h0;
			sent_reg <= 8'h00;
			pend_reg <= 1'b0;
			last_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			latch_select <= sel_next;
			shift_clock_in <= clk_next;
			shift_data_in <= data_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sent_reg <= sent_next;
			pend_reg <= pend_next;
			last_reg <= last_next;
			done_reg <= done_next;
		end
	end
endmodule // tscp_master

// ---- tb/tscp_master_asserts.sv ----
// Checker of the serial wire rules of the tuner port master
`timescale 1ns/1ps
module tscp_master_asserts (
	input wire pclk,
	input wire presetn,
	input wire latch_select,
	input wire shift_clock_in,
	input wire shift_data_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SEL_BEFORE: assert property ($rose(latch_select) |-> !shift_clock_in)
		else $error("clock high as select rose");
	AST_CLK_IN_SEL: assert property (shift_clock_in |-> latch_select)
		else $error("clock outside select");
	AST_DATA_FALL: assert property (latch_select && $past(latch_select)
		&& $changed(shift_data_in) |-> $fell(shift_clock_in)) else $error("data moved off fall");
	AST_TOP_ZERO: assert property ($rose(latch_select) |-> !shift_data_in)
		else $error("reserved bit not zero");
	AST_SEL_GAP: assert property ($fell(latch_select) |-> !shift_clock_in ##1 !latch_select)
		else $error("select gap too short");
	cover property ($fell(latch_select));
	cover property ($rose(shift_clock_in) ##1 shift_clock_in);
	cover property ($rose(latch_select) ##1 latch_select [*8]);
endmodule // tscp_master_asserts
bind tscp_master tscp_master_asserts u_chk (.*);

// ---- tb/tscp_dev_model.sv ----
// Behavioural model of the tunable capacitor serial port
`timescale 1ns/1ps
module tscp_dev_model (
	input wire latch_select,
	input wire shift_clock_in,
	input wire shift_data_in,
	output logic [7:0] state_reg
);
	logic [7:0] shift_reg = 8'h00;
	initial state_reg = 8'h00;
	// No bit count: extra leading bits fall off the top
	always @(posedge shift_clock_in) if (latch_select) begin
		shift_reg <= {shift_reg[6:0], shift_data_in};
	end
	// Bit 5 standby, bits 4:0 capacitance, applied together
	always @(negedge latch_select) state_reg <= shift_reg;
endmodule // tscp_dev_model

// ---- tb/test_tuner_serial_control_port.sv ----
// Self-checking bench of the tuner port master
`timescale 1ns/1ps
`include "tscp_defines.vh"
module test_tuner_serial_control_port;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic ls, sc, sd, err;
	logic [7:0] st;
	int n_mismatch = 0, num_checks = 0;
	logic [15:0] rows [5] = '{16'h0000, 16'h1F1F, 16'h2525, 16'hFF3F, 16'h6A2A};
	tscp_master u_tscp_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .latch_select(ls), .shift_clock_in(sc), .shift_data_in(sd));
	tscp_dev_model u_tscp_dev_model (.latch_select(ls), .shift_clock_in(sc), .shift_data_in(sd),
		.state_reg(st));
	initial forever #10 pclk = ~pclk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task send(input logic [7:0] w);
		apb(1, `TSCP_ADDR_WORD, {24'h0, w});
		apb(1, `TSCP_ADDR_CTRL, 32'h1);
		do apb(0, `TSCP_ADDR_STAT, 0); while (rd[9] !== 1'b1);
		apb(1, `TSCP_ADDR_STAT, 0);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("idle state", 8'h00, st);
		chk("select after reset", 0, ls);
		chk("clock after reset", 0, sc);
		chk("data after reset", 0, sd);
		apb(0, `TSCP_ADDR_DIV, 0);
		chk("div reset", `TSCP_DIV_RESET, rd);
		foreach (rows[i]) begin
			send(rows[i][15:8]);
			chk("latched word", rows[i][7:0], st);
			apb(0, `TSCP_ADDR_STAT, 0);
			chk("last word", rows[i][7:0], rd);
		end
		apb(1, `TSCP_ADDR_WORD, 32'h15);
		apb(1, `TSCP_ADDR_CTRL, 32'h1);
		repeat (6) @(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		chk("select in reset", 0, ls);
		chk("clock in reset", 0, sc);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `TSCP_ADDR_STAT, 0);
		chk("stat after reset", 0, rd);
		apb(0, `TSCP_ADDR_WORD, 0);
		chk("word after reset", 0, rd);
		send(8'h15);
		chk("word after mid reset", 8'h15, st);
		apb(0, 12'h010, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		apb(1, `TSCP_ADDR_DIV, 0);
		send(8'h3E);
		chk("fast divider word", 8'h3E, st);
		tally_and_finish;
	end
endmodule // test_tuner_serial_control_port
